// File: hdl/gds_supervisor.sv
// supervisory logic of a three-level leg gate driver
// Function
// - pwm input high commands switch on, low commands it off.
// - fault status output high when normal, low pulse pattern on fault.
// - desaturation while switch is on flags short circuit, reported at once.
// - shutdown starts 6.7us (1,4), 8.0us (2,3), 8.2us (5,6) after fault.
// - on fault outer switches go off before inner switches.
// - either secondary supply below threshold declares undervoltage fault and reports.
// - on fault hold status output low 5ms, then send fault word.
// - enforce 4us dead time between 1/3 and 2/4, keep longer ones.
// - pwm pulses shorter than 400ns never reach the gate.
// - only the hottest of twelve thermistor channels goes out as frequency.
// - frequency kHz is 32.768 times (0.1 + 8R/(15+11.5R)).
// - about 1ms high interval between temperature outputs.
// - fault word has sixteen bits, all ones means fault free.
// - even bits 0-10 short circuit, odd bits 1-11 undervoltage, switches one to six.
module gds_supervisor
	import gds_pkg::*;
#(
	parameter logic [15:0] HOLD_CYC  = 16'(HOLD_CYC_D),
	parameter logic [19:0] BLOCK_CYC = 20'(BLOCK_CYC_D),
	parameter logic [15:0] GAP_CYC   = 16'(GAP_CYC_D),
	parameter logic [15:0] BIT_CYC   = 16'(BIT_CYC_D)
)(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// commands and comparators, asynchronous pins
	input  wire logic [NSW-1:0]       pwm_i,
	input  wire logic [NSW-1:0]       desat_i,
	input  wire logic [NSW-1:0]       vpos_low_i,
	input  wire logic [NSW-1:0]       vneg_low_i,
	// thermistor resistances in ohms, same clock
	input  wire logic [NNTC-1:0][RW-1:0] ntc_r_i,
	// gate commands and reports
	output logic      [NSW-1:0]       gate_o,
	output logic                      fault_status_out_o,
	output logic                      temp_freq_o
);

	// ========================================
	// input synchronisers
	gds_pin_t s1_ff, s2_ff, s3_ff, cln_ff, nxt_cln;

	// a change counts once stages two and three agree
	always_comb begin
		nxt_cln = (s2_ff ~^ s3_ff) & s3_ff | (s2_ff ^ s3_ff) & cln_ff;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			cln_ff <= '0;
		end else begin
			s1_ff  <= {pwm_i, desat_i, vpos_low_i, vneg_low_i};
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			cln_ff <= nxt_cln;
		end
	end

	// ========================================
	// short pulse filter
	logic [NSW-1:0]      flt_ff, nxt_flt;
	logic [NSW-1:0][2:0] fc_ff, nxt_fc;
	logic                shp_ev;

	// a level must stand the filter time before it is taken
	always_comb begin
		nxt_flt = flt_ff;
		nxt_fc  = fc_ff;
		shp_ev  = 1'b0;
		for (int i = 0; i < NSW; i++) begin
			if (cln_ff.pwm[i] == flt_ff[i]) begin
				nxt_fc[i] = 3'h0;
				if (fc_ff[i] != 3'h0 && !flt_ff[i]) begin
					shp_ev = 1'b1;
				end
			end else if (fc_ff[i] == 3'(FILT_CYC - 1)) begin
				nxt_flt[i] = cln_ff.pwm[i];
				nxt_fc[i]  = 3'h0;
			end else begin
				nxt_fc[i] = fc_ff[i] + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flt_ff <= '0;
			fc_ff  <= '0;
		end else begin
			flt_ff <= nxt_flt;
			fc_ff  <= nxt_fc;
		end
	end

	AST_FILT_SHORT: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(flt_ff[0]) |-> $past(cln_ff.pwm[0], 1) && $past(cln_ff.pwm[0], FILT_CYC))
		else $error("pwm pulse under filter time reached the gate path");

	// ========================================
	// fault supervisor state
	gds_fst_t          st_ff, nxt_st;
	gds_flt_t          lat_ff, nxt_lat;
	logic [15:0]       tmr_ff, nxt_tmr;
	logic [19:0]       blk_ff, nxt_blk;
	logic [6:0]        sd_ff, nxt_sd;
	logic [3:0]        bit_ff, nxt_bit;
	logic [WORD_W-1:0] word_ff, nxt_word;
	logic              so_ff, nxt_so;
	logic [NSW-1:0]    gate_ff, nxt_gate;
	logic [NSW-1:0]    new_sc, new_uv;
	logic              clr;

	// fault latches, a new event wins over the clear
	always_comb begin
		new_sc     = cln_ff.desat & gate_ff;
		new_uv     = cln_ff.vpos_low | cln_ff.vneg_low;
		clr        = (st_ff == ST_HOLD) && (tmr_ff == HOLD_CYC - 16'h1);
		nxt_lat    = clr ? '0 : lat_ff;
		nxt_lat.sc = nxt_lat.sc | new_sc;
		nxt_lat.uv = nxt_lat.uv | new_uv;
		nxt_lat.shp = nxt_lat.shp | shp_ev;
	end

	// report sequence: low hold, coded word, blocking
	always_comb begin
		nxt_st   = st_ff;
		nxt_tmr  = tmr_ff;
		nxt_bit  = bit_ff;
		nxt_word = word_ff;
		nxt_so   = so_ff;
		nxt_blk  = (st_ff == ST_RUN || blk_ff == BLOCK_CYC) ? blk_ff : blk_ff + 20'h1;
		nxt_sd   = (st_ff == ST_RUN || sd_ff == 7'(R56_CYC)) ? sd_ff : sd_ff + 7'h1;
		unique case (st_ff)
			ST_RUN: begin
				nxt_so = 1'b1;
				if (|lat_ff.sc || |lat_ff.uv) begin
					nxt_st  = ST_HOLD;
					nxt_so  = 1'b0;
					nxt_tmr = 16'h0;
					nxt_blk = 20'h0;
					nxt_sd  = 7'h0;
				end
			end
			ST_HOLD: begin
				nxt_so  = 1'b0;
				nxt_tmr = tmr_ff + 16'h1;
				if (clr) begin
					nxt_word = WORD_OK;
					for (int i = 0; i < NSW; i++) begin
						nxt_word[2*i]   = ~(lat_ff.sc[i] | new_sc[i]);
						nxt_word[2*i+1] = ~(lat_ff.uv[i] | new_uv[i]);
					end
					nxt_word[SHP_BIT] = ~(lat_ff.shp | shp_ev);
					nxt_st  = ST_SEND;
					nxt_tmr = 16'h0;
					nxt_bit = 4'h0;
					nxt_so  = nxt_word[0];
				end
			end
			ST_SEND: begin
				nxt_tmr = tmr_ff + 16'h1;
				if (tmr_ff == BIT_CYC - 16'h1) begin
					nxt_tmr = 16'h0;
					if (bit_ff == 4'(WORD_W - 1)) begin
						nxt_st = ST_BLOCK;
						nxt_so = 1'b1;
					end else begin
						nxt_bit = bit_ff + 4'h1;
						nxt_so  = word_ff[nxt_bit];
					end
				end
			end
			ST_BLOCK: begin
				nxt_so = 1'b1;
				if (blk_ff >= BLOCK_CYC - 20'h1) begin
					nxt_st = ST_RUN;
				end
			end
			default: begin
				nxt_st = ST_RUN;
				nxt_so = 1'b1;
			end
		endcase
	end

	// ========================================
	// gate commands with dead time and ordered shutdown
	logic [NSW-1:0][5:0] off_ff, nxt_off;
	logic                on_ok;
	int                  p;

	always_comb begin
		nxt_gate = gate_ff;
		nxt_off  = off_ff;
		on_ok    = 1'b1;
		p        = 0;
		for (int i = 0; i < NSW; i++) begin
			nxt_off[i] = gate_ff[i] ? 6'h0 : (off_ff[i] == 6'(DEAD_CYC)) ? off_ff[i] : off_ff[i] + 6'h1;
			on_ok = 1'b1;
			p     = i ^ 2;
			if (i < 4) begin
				on_ok = !gate_ff[p] && off_ff[p] == 6'(DEAD_CYC);
				if (i >= 2) begin
					on_ok = on_ok && !flt_ff[p];
				end
			end
			if (st_ff == ST_RUN) begin
				nxt_gate[i] = flt_ff[i] && (gate_ff[i] || on_ok);
			end else begin
				nxt_gate[i] = gate_ff[i] && sd_ff < gds_resp(i);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff   <= ST_RUN;
			lat_ff  <= '0;
			tmr_ff  <= 16'h0;
			blk_ff  <= 20'h0;
			sd_ff   <= 7'h0;
			bit_ff  <= 4'h0;
			word_ff <= WORD_OK;
			so_ff   <= 1'b1;
			gate_ff <= '0;
			off_ff  <= {NSW{6'(DEAD_CYC)}};
		end else begin
			st_ff   <= nxt_st;
			lat_ff  <= nxt_lat;
			tmr_ff  <= nxt_tmr;
			blk_ff  <= nxt_blk;
			sd_ff   <= nxt_sd;
			bit_ff  <= nxt_bit;
			word_ff <= nxt_word;
			so_ff   <= nxt_so;
			gate_ff <= nxt_gate;
			off_ff  <= nxt_off;
		end
	end

	AST_SO_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff == ST_RUN |-> so_ff)
		else $error("fault status low while running");
	AST_SC_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff == ST_RUN && |(cln_ff.desat & gate_ff) |=> ##1 st_ff == ST_HOLD && !so_ff)
		else $error("desaturation not reported");
	AST_UV_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff == ST_RUN && |(cln_ff.vpos_low | cln_ff.vneg_low) |=> ##1 st_ff == ST_HOLD)
		else $error("undervoltage not reported");
	AST_RESP_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff != ST_RUN && sd_ff > 7'(R14_CYC) |-> !gate_ff[0] && !gate_ff[3])
		else $error("outer switch still on after response time");
	AST_RESP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff == ST_HOLD && $past(st_ff) == ST_HOLD && sd_ff <= 7'(R14_CYC) |-> $stable(gate_ff))
		else $error("gate changed before response time");
	AST_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff != ST_RUN && $past(st_ff) != ST_RUN && ($past(gate_ff[0]) || $past(gate_ff[3]))
		|-> $stable(gate_ff[2:1]))
		else $error("inner switch turned off before outer");
	AST_NO_ON: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff != ST_RUN && $past(st_ff) != ST_RUN |-> (gate_ff & ~$past(gate_ff)) == '0)
		else $error("switch turned on during shutdown");
	AST_HOLD_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff == ST_HOLD && tmr_ff < HOLD_CYC - 16'h1 |-> !so_ff ##1 st_ff == ST_HOLD)
		else $error("low hold ended early");
	AST_WORD_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
		st_ff == ST_SEND |-> so_ff == word_ff[bit_ff] && word_ff[RSV_HI:RSV_LO] == 3'h7)
		else $error("fault word bit mismatch");

	for (genvar g = 0; g < 4; g++) begin : g_dead
		AST_DEAD: assert property (@(posedge clk_i) disable iff (rst_i)
			$rose(gate_ff[g]) |-> $past(off_ff[g ^ 2]) == 6'(DEAD_CYC) && !gate_ff[g ^ 2])
			else $error("dead time violated");
	end

	// ========================================
	// temperature frequency output
	gds_tst_t        tst_ff, nxt_tst;
	logic [15:0]     tt_ff, nxt_tt;
	logic [15:0]     per_ff, nxt_per;
	logic [3:0]      np_ff, nxt_np;
	logic            tout_ff, nxt_tout;
	logic [RW-1:0]   rmin;

	// output period in cycles for a resistance in ohms
	function automatic logic [15:0] gds_period(input logic [RW-1:0] r);
		logic [47:0] num;
		logic [47:0] den;
		logic [47:0] f10;
		num = 48'(F10_NUM) * 48'(r);
		den = 48'(DEN_A) + 48'(DEN_B) * 48'(r);
		f10 = 48'(F10_BASE) + num / den;
		return 16'(48'(PER_NUM) / f10);
	endfunction : gds_period

	// lowest resistance is the hottest channel; gap high, then a burst
	always_comb begin
		rmin = ntc_r_i[0];
		for (int k = 1; k < NNTC; k++) begin
			if (ntc_r_i[k] < rmin) begin
				rmin = ntc_r_i[k];
			end
		end
		nxt_tst  = tst_ff;
		nxt_tt   = tt_ff + 16'h1;
		nxt_per  = per_ff;
		nxt_np   = np_ff;
		nxt_tout = tout_ff;
		unique case (tst_ff)
			T_GAP: begin
				nxt_tout = 1'b1;
				if (tt_ff == GAP_CYC - 16'h1) begin
					nxt_tst  = T_OUT;
					nxt_per  = gds_period(rmin);
					nxt_tt   = 16'h0;
					nxt_np   = 4'h0;
					nxt_tout = 1'b0;
				end
			end
			T_OUT: begin
				if (tt_ff == {1'b0, per_ff[15:1]} - 16'h1) begin
					nxt_tt = 16'h0;
					if (!tout_ff) begin
						nxt_tout = 1'b1;
					end else if (np_ff == 4'(TEMP_PER - 1)) begin
						nxt_tst = T_GAP;
					end else begin
						nxt_np   = np_ff + 4'h1;
						nxt_tout = 1'b0;
					end
				end
			end
			default: begin
				nxt_tst  = T_GAP;
				nxt_tt   = 16'h0;
				nxt_tout = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tst_ff  <= T_GAP;
			tt_ff   <= 16'h0;
			per_ff  <= 16'h0;
			np_ff   <= 4'h0;
			tout_ff <= 1'b1;
		end else begin
			tst_ff  <= nxt_tst;
			tt_ff   <= nxt_tt;
			per_ff  <= nxt_per;
			np_ff   <= nxt_np;
			tout_ff <= nxt_tout;
		end
	end

	AST_TEMP_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
		tst_ff == T_GAP && tt_ff < GAP_CYC - 16'h1 |-> tout_ff ##1 tst_ff == T_GAP)
		else $error("temperature gap cut short");

	// ========================================
	// outputs straight from flip-flops
	assign gate_o             = gate_ff;
	assign fault_status_out_o = so_ff;
	assign temp_freq_o        = tout_ff;

endmodule : gds_supervisor

// File: hdl/gds_pkg.sv
// constants, types and helpers of the gate drive supervisor
package gds_pkg;
	// ========================================
	// clock and sizes
	localparam int CLK_NS  = 100;
	localparam int CLK_HZ  = 1000000000 / CLK_NS;
	localparam int NSW     = 6;
	localparam int NNTC    = 12;
	localparam int WORD_W  = 16;
	localparam int RW      = 16;
	// ========================================
	// times in their own unit, then cycles
	localparam int DEAD_NS   = 4000;
	localparam int DEAD_CYC  = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int FILT_NS   = 400;
	localparam int FILT_CYC  = (FILT_NS / CLK_NS < 1) ? 1 : FILT_NS / CLK_NS;
	localparam int R14_NS    = 6700;
	localparam int R23_NS    = 8000;
	localparam int R56_NS    = 8200;
	localparam int R14_CYC   = R14_NS / CLK_NS;
	localparam int R23_CYC   = R23_NS / CLK_NS;
	localparam int R56_CYC   = R56_NS / CLK_NS;
	localparam int HOLD_MS   = 5;
	localparam int BLOCK_MS  = 90;
	localparam int GAP_MS    = 1;
	localparam int BIT_US    = 100;
	localparam int HOLD_CYC_D  = HOLD_MS * (1000000 / CLK_NS);
	localparam int BLOCK_CYC_D = BLOCK_MS * (1000000 / CLK_NS);
	localparam int GAP_CYC_D   = GAP_MS * (1000000 / CLK_NS);
	localparam int BIT_CYC_D   = BIT_US * (1000 / CLK_NS);
	localparam int TEMP_PER  = 8;
	// ========================================
	// thermistor transfer, ten times the frequency in hertz
	localparam int F10_BASE  = 32768;
	localparam int F10_NUM   = 5242880;
	localparam int DEN_A     = 30000;
	localparam int DEN_B     = 23;
	localparam int PER_NUM   = CLK_HZ * 10;
	// ========================================
	// reset values and field layout
	localparam logic [WORD_W-1:0] WORD_OK = 16'hffff;
	localparam int RSV_LO = 12;
	localparam int RSV_HI = 14;
	localparam int SHP_BIT = 15;
	// ========================================
	// types
	typedef enum logic [3:0] {
		ST_RUN = 4'h1, ST_HOLD = 4'h2, ST_SEND = 4'h4, ST_BLOCK = 4'h8
	} gds_fst_t;
	typedef enum logic [1:0] {T_GAP = 2'h1, T_OUT = 2'h2} gds_tst_t;
	typedef struct packed {
		logic [NSW-1:0] pwm;
		logic [NSW-1:0] desat;
		logic [NSW-1:0] vpos_low;
		logic [NSW-1:0] vneg_low;
	} gds_pin_t;
	typedef struct packed {
		logic [NSW-1:0] sc;
		logic [NSW-1:0] uv;
		logic           shp;
	} gds_flt_t;
	// ========================================
	// response cycles of a switch
	function automatic logic [6:0] gds_resp(input int i);
		return (i == 0 || i == 3) ? 7'(R14_CYC) : (i < 3) ? 7'(R23_CYC) : 7'(R56_CYC);
	endfunction : gds_resp
endpackage : gds_pkg

// File: verif/gds_fault_listener.sv
// master controller side: listens to the fault line and captures reports
module gds_fault_listener #(
	parameter int HOLD = 20,
	parameter int BITC = 4
)(
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// fault line from the driver
	input  wire logic   so_i,
	// captured report
	output logic [15:0] word_o,
	output logic        word_valid_o,
	output int          hold_len_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	// ========================================
	// low interval first, then the word lsb first, sampled mid-bit
	initial begin
		word_o = '1;
		word_valid_o = 1'b0;
		hold_len_o = 0;
		forever begin
			@(negedge clk_i);
			if (!rst_i && so_i === 1'b0) begin
				n = 0;
				repeat (HOLD) begin
					n += int'(so_i === 1'b0);
					@(negedge clk_i);
				end
				repeat (BITC / 2) @(negedge clk_i);
				for (int k = 0; k < 16; k++) begin
					word_o[k] = so_i;
					repeat (BITC) @(negedge clk_i);
				end
				hold_len_o = n;
				word_valid_o = 1'b1;
				@(negedge clk_i);
				word_valid_o = 1'b0;
			end
		end
	end
endmodule : gds_fault_listener

// File: verif/test_gds_supervisor.sv
// self-checking bench of the gate drive supervisor
module test_gds_supervisor;
	import gds_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// shortened counts of the run
	localparam int HOLD_S = 20;
	localparam int BIT_S  = 4;
	localparam int GAP_S  = 50;
	logic                    clk_i;
	logic                    rst_i;
	logic [NSW-1:0]          pwm_i;
	logic [NSW-1:0]          desat_i;
	logic [NSW-1:0]          vpos_low_i;
	logic [NSW-1:0]          vneg_low_i;
	logic [NNTC-1:0][RW-1:0] ntc_r_i;
	logic [NSW-1:0]          gate_o;
	logic                    fault_status_out_o;
	logic                    temp_freq_o;
	logic                    word_valid;
	logic [15:0]             word;
	logic [15:0]             lo;
	logic [31:0]             lf = 32'h3d74;
	logic [15:0]             exp_q[$];
	int                      hold_len, n, m, a, b, c, h, mn, mx, pe;
	int                      err_total = 0;
	int                      total_checks = 0;
	real                     rk, f;
	wire  [7:0]              obs = {temp_freq_o, fault_status_out_o, gate_o};

	gds_supervisor #(.HOLD_CYC(16'd20), .BLOCK_CYC(20'd400), .GAP_CYC(16'd50), .BIT_CYC(16'd4)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm_i), .desat_i(desat_i), .vpos_low_i(vpos_low_i),
		.vneg_low_i(vneg_low_i), .ntc_r_i(ntc_r_i), .gate_o(gate_o),
		.fault_status_out_o(fault_status_out_o), .temp_freq_o(temp_freq_o));
	gds_fault_listener #(.HOLD(HOLD_S), .BITC(BIT_S)) master (
		.clk_i(clk_i), .rst_i(rst_i), .so_i(fault_status_out_o), .word_o(word),
		.word_valid_o(word_valid), .hold_len_o(hold_len));

	// ========================================
	// clock, random source, compares
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string s);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask : chk_word
	task automatic chk_near(input int got, input int exp, input int tol, input string s);
		total_checks++;
		if (got < exp - tol || got > exp + tol) begin
			err_total++;
			$display("Error at %0t: %s got %0d want %0d", $time, s, got, exp);
		end
	endtask : chk_near
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	// bounded wait for an output level, counted in cycles
	task automatic wait_for(input int bi, input logic v, input int lim, output int k);
		k = 0;
		do begin
			@(negedge clk_i);
			k++;
			if (k > lim) begin
				err_total++;
				$display("Error at %0t: wait on output %0d ran out", $time, bi);
				print_verdict;
			end
		end while (obs[bi] !== v);
	endtask : wait_for
	task automatic hold_chk(input logic [7:0] msk, input logic [7:0] v, input int len);
		logic ok;
		ok = 1'b1;
		repeat (len) begin
			@(negedge clk_i);
			if ((obs & msk) !== (v & msk)) ok = 1'b0;
		end
		chk_word({15'h0, ok}, 16'h1, "held outputs");
	endtask : hold_chk
	task automatic ed(input int k);
		repeat (k) @(posedge clk_i);
	endtask : ed
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask : end_test

	// ========================================
	// fault words from the listener against the oldest note
	always @(posedge clk_i) begin
		if (word_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_total++;
				$display("Error at %0t: unexpected fault word", $time);
			end else begin
				chk_word(word, exp_q.pop_front(), "fault word");
				chk_near(hold_len, HOLD_S, 0, "low hold");
			end
		end
	end

	// ========================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		pwm_i = '0;
		desat_i = '0;
		vpos_low_i = '0;
		vneg_low_i = '0;
		ntc_r_i = '1;
		ed(4);
		@(negedge clk_i);
		chk_word({8'h0, obs}, 16'h00c0, "reset outputs");
		@(posedge clk_i);
		rst_i <= 1'b0;
		end_test("reset");
		// turn-on latency, then short pulses of both polarities
		ed(10);
		pwm_i[4] <= 1'b1;
		wait_for(4, 1'b1, 20, n);
		chk_near(n, 9, 1, "turn-on latency");
		@(posedge clk_i);
		pwm_i[5:4] <= 2'b10;
		ed(3);
		pwm_i[5:4] <= 2'b01;
		hold_chk(8'h30, 8'h10, 20);
		@(posedge clk_i);
		pwm_i[5] <= 1'b1;
		wait_for(5, 1'b1, 20, n);
		end_test("pulse");
		// forced dead time, then a longer commanded one
		@(posedge clk_i);
		pwm_i[2] <= 1'b1;
		wait_for(2, 1'b1, 60, n);
		@(posedge clk_i);
		pwm_i[2] <= 1'b0;
		pwm_i[0] <= 1'b1;
		wait_for(2, 1'b0, 20, n);
		wait_for(0, 1'b1, 80, n);
		chk_near(n, DEAD_CYC, 1, "forced dead time");
		@(posedge clk_i);
		pwm_i[1] <= 1'b1;
		wait_for(1, 1'b1, 60, n);
		@(posedge clk_i);
		pwm_i[1] <= 1'b0;
		wait_for(1, 1'b0, 20, n);
		ed(61 - n);
		pwm_i[3] <= 1'b1;
		wait_for(3, 1'b1, 80, m);
		chk_near(60 + m - n, 60, 1, "long dead time");
		@(posedge clk_i);
		pwm_i[3] <= 1'b0;
		pwm_i[1] <= 1'b1;
		wait_for(1, 1'b1, 80, n);
		end_test("dead time");
		// short circuit on switch one: report, turn-off order, lockout
		exp_q.push_back(16'h7ffe);
		@(posedge clk_i);
		desat_i[0] <= 1'b1;
		wait_for(6, 1'b0, 15, n);
		chk_near(n, 6, 2, "fault report delay");
		// drop the trip before word capture, or it latches a second report
		@(posedge clk_i);
		desat_i[0] <= 1'b0;
		wait_for(0, 1'b0, 100, a);
		chk_near(a, R14_CYC, 1, "outer switch off");
		wait_for(1, 1'b0, 30, b);
		chk_near(a + b, R23_CYC, 1, "inner switch off");
		wait_for(4, 1'b0, 30, c);
		chk_near(a + b + c, R56_CYC, 1, "third pair off");
		chk_word({15'h0, obs[5]}, 16'h0, "sixth switch off");
		@(posedge clk_i);
		pwm_i <= 6'h04;
		hold_chk(8'h04, 8'h00, 200);
		wait_for(2, 1'b1, 400, n);
		@(posedge clk_i);
		pwm_i <= '0;
		ed(60);
		end_test("short circuit");
		// undervoltage on either supply
		for (int k = 0; k < 2; k++) begin
			exp_q.push_back(k != 0 ? 16'hf7ff : 16'hfffd);
			@(posedge clk_i);
			if (k != 0) vneg_low_i[5] <= 1'b1;
			else vpos_low_i[0] <= 1'b1;
			wait_for(6, 1'b0, 15, n);
			@(posedge clk_i);
			vpos_low_i <= '0;
			vneg_low_i <= '0;
			ed(450);
		end
		chk_near(exp_q.size(), 0, 0, "reports left");
		end_test("undervoltage");
		// hottest channel out as a frequency, with its gap
		for (int r = 0; r < 2; r++) begin
			lf = lfsr(lf);
			h = int'(lf % 12);
			lo = 16'd2000 + 16'(lf[12:0]);
			@(posedge clk_i);
			for (int j = 0; j < NNTC; j++) begin
				lf = lfsr(lf);
				ntc_r_i[j] <= (j == h) ? lo : 16'd20000 + 16'(lf[13:0]);
			end
			rk = lo / 1000.0;
			f = 32768.0 * (0.1 + 8.0 * rk / (15.0 + 11.5 * rk));
			pe = $rtoi(1.0e7 / f + 0.5);
			ed(6000);
			wait_for(7, 1'b1, 2000, n);
			wait_for(7, 1'b0, 2000, n);
			mn = 100000;
			mx = 0;
			repeat (10) begin
				wait_for(7, 1'b1, 2000, a);
				wait_for(7, 1'b0, 2000, b);
				if (a + b < mn) mn = a + b;
				if (a + b > mx) mx = a + b;
			end
			chk_near(mn, pe, 2, "temperature period");
			chk_near(mx - mn, GAP_S, 2, "temperature gap");
		end
		end_test("temperature");
		print_verdict;
	end
endmodule : test_gds_supervisor
